// ===== logic/free_running_timer.v
/*
  Free-running timer control: counter clock selection, capture edge and
  buffer control, compare outputs with level modes and an addend mode on output A, shared
  register addressing and module stop, reached over an AHB-Lite slave.
  Assumes one master issuing single word transfers and pins asynchronous
  to hclk. Flags and interrupts are outside this block.
*/

`timescale 1ns/100ps
`default_nettype none

`include "frt_ctrl_defs.vh"

module free_running_timer (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hw_standby,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Pins
  input  wire        ext_count_clk_in,
  input  wire        capture_in_a,
  input  wire        capture_in_b,
  input  wire        capture_in_c,
  input  wire        capture_in_d,
  output reg         compare_out_a,
  output reg         compare_out_a_oe_n,
  output reg         compare_out_b,
  output reg         compare_out_b_oe_n,
  // Status
  output reg         timer_stopped
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg  [7:0]  timer_control;
  reg  [7:0]  output_compare_control;
  reg  [15:0] module_stop_control;
  reg  [15:0] free_counter;
  reg  [15:0] compare_reg_a;
  reg  [15:0] compare_reg_b;
  reg  [15:0] capture_reg_a;
  reg  [15:0] capture_reg_b;
  reg  [15:0] capture_reg_c;
  reg  [15:0] capture_reg_d;
  reg  [15:0] rise_addend_reg;
  reg  [15:0] fall_addend_reg;
  reg  [15:0] capture_mask_reg;
  reg  [4:0]  prescale;
  reg         mask_active;
  reg         addend_phase;
  reg         wr_pending;
  reg  [7:0]  wr_addr;

  wire        edge_sel_chan_a   = timer_control[`TC_EDGE_A];
  wire        edge_sel_chan_b   = timer_control[`TC_EDGE_B];
  wire        edge_sel_chan_c   = timer_control[`TC_EDGE_C];
  wire        edge_sel_chan_d   = timer_control[`TC_EDGE_D];
  wire        buffer_en_a       = timer_control[`TC_BUF_A];
  wire        buffer_en_b       = timer_control[`TC_BUF_B];
  wire [1:0]  clk_sel           = {timer_control[`TC_CLK_HI], timer_control[`TC_CLK_LO]};
  wire        cap_d_mask_mode   = output_compare_control[`OC_CAP_D_MASK];
  wire        cmp_a_addend_mode = output_compare_control[`OC_CMP_A_ADD];
  wire        capture_access_sel = output_compare_control[`OC_CAP_SEL];
  wire        compare_access_sel = output_compare_control[`OC_CMP_SEL];
  wire        timer_stop_bit    = module_stop_control[`TIMER_STOP_POS];

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  wire [4:0] pin_rise;
  wire [4:0] pin_fall;

  pin_edge_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .pin   ({ext_count_clk_in, capture_in_d, capture_in_c, capture_in_b, capture_in_a}),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // Pulses shorter than 1.5 hclk periods may be missed by the synchroniser.
  wire ext_rise = pin_rise[4];
  wire cap_a_ev = edge_sel_chan_a ? pin_rise[0] : pin_fall[0];
  wire cap_b_ev = edge_sel_chan_b ? pin_rise[1] : pin_fall[1];
  wire cap_c_ev = edge_sel_chan_c ? pin_rise[2] : pin_fall[2];
  wire cap_d_ev = edge_sel_chan_d ? pin_rise[3] : pin_fall[3];

  // ----------------------------------------------------------------------
  // Counter clock selection
  // ----------------------------------------------------------------------
  reg count_tick;

  always @*
  begin
    count_tick = 1'b0;
    case (clk_sel)
      `CLK_DIV2:  count_tick = (prescale & `PRE_MASK_DIV2) == `PRE_END_DIV2;
      `CLK_DIV8:  count_tick = (prescale & `PRE_MASK_DIV8) == `PRE_END_DIV8;
      `CLK_DIV32: count_tick = prescale == `PRE_END_DIV32;
      `CLK_EXT:   count_tick = ext_rise;
      default:    count_tick = 1'b0;
    endcase
  end

  wire running = ~timer_stop_bit;
  wire tick    = running & count_tick;

  // Match is taken in the last cycle of a count value, just before it moves on.
  wire match_a = tick & (free_counter == compare_reg_a);
  wire match_b = tick & (free_counter == compare_reg_b);

  // ----------------------------------------------------------------------
  // Capture mask window for channel D
  // ----------------------------------------------------------------------
  wire [15:0] mask_end    = capture_reg_d + {capture_mask_reg[14:0], 1'b0};
  wire        mask_usable = cap_d_mask_mode & (capture_mask_reg != 16'h0000);
  wire        cap_d_take  = running & cap_d_ev & ~(mask_usable & mask_active);

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  wire        addr_phase = hsel & htrans[1] & hready;
  wire        do_write   = wr_pending;
  wire [15:0] wdata      = hwdata[15:0];

  wire wr_tc   = do_write & (wr_addr == `OFS_TIMER_CONTROL);
  wire wr_oc   = do_write & (wr_addr == `OFS_OUT_CMP_CONTROL);
  wire wr_ms   = do_write & (wr_addr == `OFS_MODULE_STOP);
  wire wr_frc  = do_write & (wr_addr == `OFS_FREE_COUNTER);
  wire wr_cmp  = do_write & (wr_addr == `OFS_COMPARE_SLOT);
  wire wr_sl_a = do_write & (wr_addr == `OFS_SHARED_SLOT_A);
  wire wr_sl_b = do_write & (wr_addr == `OFS_SHARED_SLOT_B);
  wire wr_sl_c = do_write & (wr_addr == `OFS_SHARED_SLOT_C);
  wire wr_cmp_a = wr_cmp & ~compare_access_sel;
  wire wr_cmp_b = wr_cmp & compare_access_sel;

  reg [15:0] next_rdata;

  always @*
  begin
    next_rdata = 16'h0000;
    case (haddr[7:0])
      `OFS_TIMER_CONTROL:   next_rdata = {8'h00, timer_control};
      `OFS_OUT_CMP_CONTROL: next_rdata = {8'h00, output_compare_control};
      `OFS_MODULE_STOP:     next_rdata = module_stop_control;
      `OFS_FREE_COUNTER:    next_rdata = free_counter;
      `OFS_COMPARE_SLOT:    next_rdata = compare_access_sel ? compare_reg_b : compare_reg_a;
      `OFS_SHARED_SLOT_A:   next_rdata = capture_access_sel ? rise_addend_reg : capture_reg_a;
      `OFS_SHARED_SLOT_B:   next_rdata = capture_access_sel ? fall_addend_reg : capture_reg_b;
      `OFS_SHARED_SLOT_C:   next_rdata = capture_access_sel ? capture_mask_reg : capture_reg_c;
      `OFS_CAPTURE_D:       next_rdata = capture_reg_d;
      default:              next_rdata = 16'h0000;
    endcase
  end

  // Zero wait states: read data is registered at the address phase edge.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b0;
      hresp      <= 1'b0;
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
    end
    else
    begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pending <= addr_phase & hwrite;
      if (addr_phase)
      begin
        wr_addr <= haddr[7:0];
      end
      if (addr_phase & ~hwrite)
      begin
        hrdata <= {16'h0000, next_rdata};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_control          <= `RST_TIMER_CONTROL;
      output_compare_control <= `RST_OUT_CMP_CTRL;
      module_stop_control    <= `RST_MODULE_STOP;
    end
    else if (hw_standby)
    begin
      timer_control          <= `RST_TIMER_CONTROL;
      output_compare_control <= `RST_OUT_CMP_CTRL;
      module_stop_control    <= `RST_MODULE_STOP;
    end
    else
    begin
      if (wr_tc)
      begin
        timer_control <= wdata[7:0];
      end
      if (wr_oc)
      begin
        output_compare_control <= wdata[7:0];
      end
      // The write lands at the end of its data phase, so the stop follows that cycle.
      if (wr_ms)
      begin
        module_stop_control <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prescale     <= 5'h00;
      free_counter <= 16'h0000;
    end
    else if (hw_standby)
    begin
      prescale     <= 5'h00;
      free_counter <= 16'h0000;
    end
    else
    begin
      if (running)
      begin
        prescale <= prescale + 5'h01;
      end
      // A software write beats an increment in the same cycle.
      if (wr_frc)
      begin
        free_counter <= wdata;
      end
      else if (tick)
      begin
        free_counter <= free_counter + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      capture_reg_a <= 16'h0000;
      capture_reg_b <= 16'h0000;
      capture_reg_c <= 16'h0000;
      capture_reg_d <= 16'h0000;
      mask_active   <= 1'b0;
    end
    else
    begin
      // Captures run whatever the access select says.
      if (running & cap_a_ev)
      begin
        capture_reg_a <= free_counter;
        if (buffer_en_a)
        begin
          capture_reg_c <= capture_reg_a;
        end
      end
      if (running & cap_b_ev)
      begin
        capture_reg_b <= free_counter;
        if (buffer_en_b)
        begin
          capture_reg_d <= capture_reg_b;
        end
      end
      // In buffer mode channel C and D edges no longer load their registers.
      if (running & cap_c_ev & ~buffer_en_a)
      begin
        capture_reg_c <= free_counter;
      end
      if (cap_d_take & ~buffer_en_b)
      begin
        capture_reg_d <= free_counter;
      end
      // The window opens on a channel D capture and closes at counter = end.
      if (~mask_usable)
      begin
        mask_active <= 1'b0;
      end
      else if (cap_d_take)
      begin
        mask_active <= 1'b1;
      end
      else if (tick & (free_counter == mask_end))
      begin
        mask_active <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Compare registers and outputs
  // ----------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      compare_reg_a      <= 16'hffff;
      compare_reg_b      <= 16'hffff;
      rise_addend_reg    <= 16'hffff;
      fall_addend_reg    <= 16'hffff;
      capture_mask_reg   <= 16'h0000;
      addend_phase       <= 1'b0;
      compare_out_a      <= 1'b0;
      compare_out_b      <= 1'b0;
      compare_out_a_oe_n <= 1'b1;
      compare_out_b_oe_n <= 1'b1;
      timer_stopped      <= 1'b1;
    end
    else
    begin
      compare_out_a_oe_n <= ~output_compare_control[`OC_OUT_EN_A];
      compare_out_b_oe_n <= ~output_compare_control[`OC_OUT_EN_B];
      timer_stopped      <= timer_stop_bit;
      if (wr_sl_a & capture_access_sel)
      begin
        rise_addend_reg <= wdata;
      end
      if (wr_sl_b & capture_access_sel)
      begin
        fall_addend_reg <= wdata;
      end
      if (wr_sl_c & capture_access_sel)
      begin
        capture_mask_reg <= wdata;
      end
      if (wr_cmp_b)
      begin
        compare_reg_b <= wdata;
      end
      // A software write to compare A wins over the automatic reload.
      if (wr_cmp_a)
      begin
        compare_reg_a <= wdata;
        addend_phase  <= 1'b0;
      end
      else if (match_a & cmp_a_addend_mode)
      begin
        compare_reg_a <= compare_reg_a + (addend_phase ? fall_addend_reg : rise_addend_reg);
        addend_phase  <= ~addend_phase;
      end
      if (~cmp_a_addend_mode)
      begin
        addend_phase <= 1'b0;
      end
      // In addend mode the pin goes low after the rise span and high after the fall.
      if (match_a)
      begin
        compare_out_a <= cmp_a_addend_mode ? ~addend_phase
                                           : output_compare_control[`OC_LEVEL_A];
      end
      if (match_b)
      begin
        compare_out_b <= output_compare_control[`OC_LEVEL_B];
      end
    end
  end

endmodule // free_running_timer

`default_nettype wire

// ===== logic/frt_ctrl_defs.vh
/*
  Constants of the free-running timer control block: register byte offsets,
  field positions, reset values and prescaler terminal counts.
  Assumes inclusion by bare name from the design files under logic/.
*/
`ifndef FRT_CTRL_DEFS_VH
`define FRT_CTRL_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_TIMER_CONTROL    8'h00
`define OFS_OUT_CMP_CONTROL  8'h04
`define OFS_MODULE_STOP      8'h08
`define OFS_FREE_COUNTER     8'h0c
`define OFS_COMPARE_SLOT     8'h10
`define OFS_SHARED_SLOT_A    8'h14
`define OFS_SHARED_SLOT_B    8'h18
`define OFS_SHARED_SLOT_C    8'h1c
`define OFS_CAPTURE_D        8'h20

// ----------------------------------------------------------------------
// Timer control fields
// ----------------------------------------------------------------------
`define TC_EDGE_A     7
`define TC_EDGE_B     6
`define TC_EDGE_C     5
`define TC_EDGE_D     4
`define TC_BUF_A      3
`define TC_BUF_B      2
`define TC_CLK_HI     1
`define TC_CLK_LO     0

// ----------------------------------------------------------------------
// Output compare control fields
// ----------------------------------------------------------------------
`define OC_CAP_D_MASK  7
`define OC_CMP_A_ADD   6
`define OC_CAP_SEL     5
`define OC_CMP_SEL     4
`define OC_OUT_EN_A    3
`define OC_OUT_EN_B    2
`define OC_LEVEL_A     1
`define OC_LEVEL_B     0

// ----------------------------------------------------------------------
// Reset values and module stop position
// ----------------------------------------------------------------------
`define RST_TIMER_CONTROL  8'h00
`define RST_OUT_CMP_CTRL   8'h00
`define RST_MODULE_STOP    16'h3fff
`define TIMER_STOP_POS     13

// ----------------------------------------------------------------------
// Clock select codes and prescaler terminal counts
// ----------------------------------------------------------------------
`define CLK_DIV2      2'b00
`define CLK_DIV8      2'b01
`define CLK_DIV32     2'b10
`define CLK_EXT       2'b11
`define PRE_END_DIV2  5'h01
`define PRE_END_DIV8  5'h07
`define PRE_END_DIV32 5'h1f
`define PRE_MASK_DIV2 5'h01
`define PRE_MASK_DIV8 5'h07

`endif

// ===== logic/pin_edge_sync.v
/*
  Two-flop synchroniser with edge detection for a group of pin inputs.
  Assumes the pins are asynchronous to clk; edges come out as one-cycle
  registered pulses two to three cycles after the pin changes.
*/
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync #(
  parameter WIDTH = 5
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Pins and edge pulses
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] rise,
  output reg  [WIDTH-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta;
      reg stable;
      reg last;
      // The first flop feeds only the second; edges are taken from later stages.
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta    <= 1'b0;
          stable  <= 1'b0;
          last    <= 1'b0;
          rise[i] <= 1'b0;
          fall[i] <= 1'b0;
        end
        else
        begin
          meta    <= pin[i];
          stable  <= meta;
          last    <= stable;
          rise[i] <= stable & ~last;
          fall[i] <= ~stable & last;
        end
      end
    end
  endgenerate

endmodule // pin_edge_sync

`default_nettype wire

// ===== tb/free_running_timer_asserts.sv
/*
  Checker for the free-running timer control block: pin enables, pin levels
  and the stop status against a shadow of the bus writes.
  Assumes it is bound to free_running_timer and that no register write is
  issued while hardware standby is asserted.
*/
`timescale 1ns/100ps
`default_nettype none

module free_running_timer_asserts (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hw_standby,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // Pins and status
  input wire logic        compare_out_a,
  input wire logic        compare_out_a_oe_n,
  input wire logic        compare_out_b,
  input wire logic        compare_out_b_oe_n,
  input wire logic        timer_stopped
);
  // ----------------------------------------------------------------------
  // Shadow of the two control registers
  // ----------------------------------------------------------------------
  logic       wr_oc;
  logic       wr_ms;
  logic [7:0] oc;
  logic       stop;
  wire        take = hsel & htrans[1] & hready & hwrite;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_oc <= 1'b0;
      wr_ms <= 1'b0;
      oc    <= 8'h00;
      stop  <= 1'b1;
    end
    else
    begin
      wr_oc <= take & (haddr[7:0] == 8'h04);
      wr_ms <= take & (haddr[7:0] == 8'h08);
      if (hw_standby)
      begin
        oc   <= 8'h00;
        stop <= 1'b1;
      end
      else
      begin
        if (wr_oc)
          oc <= hwdata[7:0];
        if (wr_ms)
          stop <= hwdata[13];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_oe_a; compare_out_a_oe_n == !$past(oc[3]); endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a enable wrong");
  property p_oe_b; compare_out_b_oe_n == !$past(oc[2]); endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin b enable wrong");
  property p_stop; timer_stopped == $past(stop); endproperty
  a_stop: assert property (p_stop) else $error("stop status wrong");
  property p_stop_rst; $rose(hresetn) |-> timer_stopped; endproperty
  a_stop_rst: assert property (p_stop_rst) else $error("not stopped after reset");
  property p_lvl_a;
    $changed(compare_out_a) && !$past(oc[6]) |-> compare_out_a == $past(oc[1]);
  endproperty
  a_lvl_a: assert property (p_lvl_a) else $error("pin a level wrong");
  property p_lvl_b; $changed(compare_out_b) |-> compare_out_b == $past(oc[0]); endproperty
  a_lvl_b: assert property (p_lvl_b) else $error("pin b level wrong");
  property p_sb_oe; hw_standby |-> ##2 compare_out_a_oe_n && compare_out_b_oe_n; endproperty
  a_sb_oe: assert property (p_sb_oe) else $error("standby left pins on");
  property p_sb_stop; hw_standby |-> ##2 timer_stopped[*2]; endproperty
  a_sb_stop: assert property (p_sb_stop) else $error("standby left timer on");
endmodule // free_running_timer_asserts

bind free_running_timer free_running_timer_asserts u_free_running_timer_asserts (
  .hclk, .hresetn, .hw_standby, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .compare_out_a, .compare_out_a_oe_n, .compare_out_b, .compare_out_b_oe_n, .timer_stopped
);

`default_nettype wire

// ===== tb/testbench.sv
/*
  Self-checking bench for the free-running timer control block.
  Assumes the slave answers with hreadyout high and that pins are sampled
  a few cycles after they change.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic hclk = 0, hresetn = 0, hw_standby = 0, hsel = 0, hwrite = 0;
  logic ext_count_clk_in = 0, capture_in_a = 0, capture_in_b = 0;
  logic capture_in_c = 0, capture_in_d = 1;
  logic [31:0] haddr = 0, hwdata = 0, q, a, b;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  wire  [31:0] hrdata;
  wire hreadyout, hresp, compare_out_a, compare_out_a_oe_n;
  wire compare_out_b, compare_out_b_oe_n, timer_stopped;
  int  error_cnt = 0, total_checks = 0;

  free_running_timer u_free_running_timer (
    .hclk, .hresetn, .hw_standby, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .ext_count_clk_in,
    .capture_in_a, .capture_in_b, .capture_in_c, .capture_in_d, .compare_out_a,
    .compare_out_a_oe_n, .compare_out_b, .compare_out_b_oe_n, .timer_stopped
  );

  always #4 hclk = ~hclk;

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // A hung slave would stall the whole run, so every wait is bounded.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 16)
      begin
        error_cnt++;
        summarize();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0);
    chk(q, exp);
  endtask

  // Two counter reads whose load edges lie exactly 64 cycles apart.
  task automatic span(input logic [31:0] exp);
    bus(1'b0, 8'h0c, 32'h0);
    a = q;
    cyc(62);
    bus(1'b0, 8'h0c, 32'h0);
    chk((q - a) & 32'hffff, exp);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h3fff);
    rd(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, timer_stopped}, 32'h1);
    chk({30'h0, compare_out_a_oe_n, compare_out_b_oe_n}, 32'h3);
  endtask

  task automatic t_clock;
    int k;
    span(32'h0);
    wr(8'h08, 32'h1fff);
    rd(8'h08, 32'h1fff);
    for (k = 0; k < 3; k++)
    begin
      wr(8'h00, k);
      span(32'd32 >> (2 * k));
    end
    wr(8'h08, 32'h3fff);
    span(32'h0);
    wr(8'h08, 32'h1fff);
    wr(8'h00, 32'h3);
    bus(1'b0, 8'h0c, 32'h0);
    b = q;
    repeat (5)
    begin
      ext_count_clk_in <= 1'b1;
      cyc(4);
      ext_count_clk_in <= 1'b0;
      cyc(4);
    end
    cyc(8);
    rd(8'h0c, (b + 32'h5) & 32'hffff);
  endtask

  task automatic t_compare;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h10);
    wr(8'h10, 32'h50);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h40);
    rd(8'h10, 32'h40);
    wr(8'h04, 32'h10);
    rd(8'h10, 32'h50);
    wr(8'h04, 32'h0f);
    wr(8'h0c, 32'h0);
    cyc(250);
    chk({30'h0, compare_out_a, compare_out_b}, 32'h3);
    chk({30'h0, compare_out_a_oe_n, compare_out_b_oe_n}, 32'h0);
    wr(8'h04, 32'h00);
    cyc(3);
    chk({30'h0, compare_out_a_oe_n, compare_out_b_oe_n}, 32'h3);
    wr(8'h04, 32'h0c);
    wr(8'h0c, 32'h0);
    cyc(250);
    chk({30'h0, compare_out_a, compare_out_b}, 32'h0);
  endtask

  task automatic t_addend;
    wr(8'h04, 32'h20);
    wr(8'h14, 32'h10);
    wr(8'h18, 32'h10);
    rd(8'h14, 32'h10);
    rd(8'h18, 32'h10);
    wr(8'h04, 32'h48);
    wr(8'h10, 32'h40);
    wr(8'h0c, 32'h0);
    cyc(140);
    chk({31'h0, compare_out_a}, 32'h1);
    rd(8'h10, 32'h50);
    cyc(30);
    chk({31'h0, compare_out_a}, 32'h0);
  endtask

  task automatic cap_d(input logic [31:0] cnt, input logic lvl);
    wr(8'h0c, cnt);
    capture_in_d <= lvl;
    cyc(8);
  endtask

  task automatic cap_ab(input logic [31:0] cnt, input logic lvl);
    wr(8'h0c, cnt);
    capture_in_a <= lvl;
    capture_in_b <= lvl;
    cyc(8);
  endtask

  task automatic t_capture;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h03);
    cap_d(32'h100, 1'b0);
    rd(8'h20, 32'h100);
    cap_d(32'h200, 1'b1);
    rd(8'h20, 32'h100);
    wr(8'h00, 32'h13);
    cap_d(32'h300, 1'b0);
    rd(8'h20, 32'h100);
    cap_d(32'h400, 1'b1);
    rd(8'h20, 32'h400);
    wr(8'h04, 32'h20);
    wr(8'h00, 32'hcf);
    cap_ab(32'h500, 1'b1);
    cap_ab(32'h500, 1'b0);
    cap_ab(32'h600, 1'b1);
    wr(8'h04, 32'h0);
    rd(8'h14, 32'h600);
    rd(8'h1c, 32'h500);
    rd(8'h18, 32'h600);
    rd(8'h20, 32'h500);
  endtask

  // The window opened by a D capture at 0x700 closes at the tick seen at 0x710.
  task automatic t_mask;
    wr(8'h00, 32'h13);
    wr(8'h04, 32'h20);
    wr(8'h1c, 32'h8);
    wr(8'h04, 32'h80);
    cap_d(32'h700, 1'b0);
    cap_d(32'h700, 1'b1);
    cap_d(32'h705, 1'b0);
    cap_d(32'h705, 1'b1);
    rd(8'h20, 32'h700);
    wr(8'h0c, 32'h710);
    ext_count_clk_in <= 1'b1;
    cyc(4);
    ext_count_clk_in <= 1'b0;
    cyc(8);
    cap_d(32'h800, 1'b0);
    cap_d(32'h800, 1'b1);
    rd(8'h20, 32'h800);
  endtask

  task automatic t_standby;
    wr(8'h04, 32'h0c);
    wr(8'h08, 32'h1fff);
    hw_standby <= 1'b1;
    cyc(1);
    hw_standby <= 1'b0;
    cyc(2);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h3fff);
    chk({31'h0, timer_stopped}, 32'h1);
  endtask

  initial
  begin
    cyc(6);
    hresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_clock();
    t_compare();
    t_addend();
    t_capture();
    t_mask();
    t_standby();
    summarize();
  end
endmodule // testbench

`default_nettype wire
